// ==== core/sbba_defs.svh ====
`ifndef SBBA_DEFS_SVH
`define SBBA_DEFS_SVH

`define SBBA_DATA_W        32
`define SBBA_MASK_W        4
`define SBBA_ADDR_W        12
`define SBBA_COL_W         9
`define SBBA_BANKS         4
`define SBBA_BANK_W        2
`define SBBA_AP_BIT        10
`define SBBA_STORE_ROW_W   2
`define SBBA_STORE_AW      13
`define SBBA_FIFO_DEPTH    8
`define SBBA_TIME_W        4
`define SBBA_FIFO_W        36

`define SBBA_BL_CODE_1     3'h0
`define SBBA_BL_CODE_2     3'h1
`define SBBA_BL_CODE_4     3'h2
`define SBBA_BL_CODE_8     3'h3
`define SBBA_BL_CODE_FULL  3'h7

`define SBBA_WRAP_1        9'h000
`define SBBA_WRAP_2        9'h001
`define SBBA_WRAP_4        9'h003
`define SBBA_WRAP_8        9'h007
`define SBBA_WRAP_FULL     9'h1ff

`define SBBA_WR_AP_DELAY   2'h2

`endif

// ==== core/sbba_fifo.sv ====
module sbba_fifo #(
   parameter int WIDTH = 36,
   parameter int DEPTH = 8
) (
   input  wire logic             core_clk_i,
   input  wire logic             nrst_i,
   input  wire logic             in_valid_i,
   output logic                  in_ready_o,
   input  wire logic [WIDTH-1:0] in_data_i,
   output logic                  out_valid_o,
   input  wire logic             out_ready_i,
   output logic      [WIDTH-1:0] out_data_o
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] buf_r [0:DEPTH-1];
   logic [AW:0]      wr_ptr_r;
   logic [AW:0]      rd_ptr_r;
   logic             full;
   logic             empty;

   assign empty = (wr_ptr_r == rd_ptr_r);
   assign full  = (wr_ptr_r[AW] != rd_ptr_r[AW]) &&
                  (wr_ptr_r[AW-1:0] == rd_ptr_r[AW-1:0]);
   assign in_ready_o  = !full;
   assign out_valid_o = !empty;
   assign out_data_o  = buf_r[rd_ptr_r[AW-1:0]];

   always_ff @(posedge core_clk_i) begin
      if (in_valid_i && !full) begin
         buf_r[wr_ptr_r[AW-1:0]] <= in_data_i;
      end
   end

   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
      end else begin
         if (in_valid_i && !full) begin
            wr_ptr_r <= wr_ptr_r + 1'b1;
         end
         if (out_ready_i && !empty) begin
            rd_ptr_r <= rd_ptr_r + 1'b1;
         end
      end
   end
endmodule

// ==== core/sbba_mem_if.sv ====
`include "sbba_defs.svh"

interface sbba_mem_if;
   logic [`SBBA_STORE_AW-1:0] addr;
   logic                      rd_en;
   logic                      wr_en;
   logic [`SBBA_MASK_W-1:0]   be;
   logic [`SBBA_DATA_W-1:0]   wdata;
   logic [`SBBA_DATA_W-1:0]   rdata;

   modport ctl (output addr, rd_en, wr_en, be, wdata, input rdata);
   modport store (input addr, rd_en, wr_en, be, wdata, output rdata);
endinterface

// ==== core/sbba_pkg.sv ====
package sbba_pkg;

   typedef enum logic [2:0] {
      SBBA_CMD_NOP,
      SBBA_CMD_ACT,
      SBBA_CMD_READ,
      SBBA_CMD_WRITE,
      SBBA_CMD_STOP,
      SBBA_CMD_PRE,
      SBBA_CMD_OTHER
   } sbba_cmd_t;

   typedef enum logic [1:0] {
      SBBA_OP_IDLE,
      SBBA_OP_READ,
      SBBA_OP_WRITE
   } sbba_op_t;

endpackage

// ==== core/sbba_store.sv ====
`include "sbba_defs.svh"

module sbba_store (
   input  wire logic core_clk_i,
   sbba_mem_if.store mp
);
   logic [`SBBA_DATA_W-1:0] mem_r [0:(1 << `SBBA_STORE_AW)-1];
   logic [`SBBA_DATA_W-1:0] rdata_r;

   always_ff @(posedge core_clk_i) begin
      if (mp.wr_en) begin
         for (int b = 0; b < `SBBA_MASK_W; b++) begin
            if (mp.be[b]) begin
               mem_r[mp.addr][8*b +: 8] <= mp.wdata[8*b +: 8];
            end
         end
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (mp.rd_en) begin
         rdata_r <= mem_r[mp.addr];
      end
   end

   assign mp.rdata = rdata_r;
endmodule

// ==== core/sbba_top.sv ====
// Notes on behaviour
// - Read is CAS low, RAS and WE high; write adds WE low.
// - Read or write commands are accepted every cycle, any open bank.
// - Bursts follow programmed length 1, 2, 4, 8 or page, and type except page, which is always sequential.
// - First write word arrives with the command; data after the burst ignored.
// - Read over read restarts full burst; old data runs until new latency.
// - Write over write restarts at the new column for a full burst.
// - Read ends a write burst at once; leftover write data is dropped.
// - Burst stop ends a page burst, leaves bank open; otherwise illegal.
// - Burst stop is WE low only; read outputs float after CAS latency.
// - Sequential order increments and wraps inside the burst without carry.
// - Interleave order is start column exclusive-or beat number.
// - Address bit ten selects auto-precharge; reads precharge latency-minus-one beats early.
// - Write auto-precharge starts two clocks after the last write beat.
// - Bank select picks the bank for activate, read and write.
// - Mask floats read outputs two cycles later, blocks writes at once.
`include "sbba_defs.svh"

module sbba_top (
   input  wire logic                     core_clk_i,
   input  wire logic                     nrst_i,
   input  wire logic                     cs_n_i,
   input  wire logic                     ras_n_i,
   input  wire logic                     cas_n_i,
   input  wire logic                     we_n_i,
   input  wire logic [`SBBA_BANK_W-1:0]  bank_select_i,
   input  wire logic [`SBBA_ADDR_W-1:0]  addr_i,
   input  wire logic [`SBBA_MASK_W-1:0]  dqm_i,
   input  wire logic [`SBBA_DATA_W-1:0]  dq_i,
   output logic      [`SBBA_DATA_W-1:0]  dq_o,
   output logic      [`SBBA_MASK_W-1:0]  dq_oe_n_o,
   input  wire logic [2:0]               mode_burst_len_i,
   input  wire logic                     mode_interleave_i,
   input  wire logic [1:0]               mode_cas_latency_i,
   output logic      [`SBBA_BANKS-1:0]   bank_open_o,
   output logic                          burst_active_o
);
   localparam int TW = `SBBA_TIME_W;
   localparam int CW = `SBBA_COL_W;

   // Pins come from logic on the same clock, so no synchroniser is used.

   function automatic sbba_pkg::sbba_cmd_t decode_cmd(
      input logic cs_n,
      input logic ras_n,
      input logic cas_n,
      input logic we_n
   );
      sbba_pkg::sbba_cmd_t c;
      c = sbba_pkg::SBBA_CMD_NOP;
      if (!cs_n) begin
         unique case ({ras_n, cas_n, we_n})
            3'h3:    c = sbba_pkg::SBBA_CMD_ACT;
            3'h5:    c = sbba_pkg::SBBA_CMD_READ;
            3'h4:    c = sbba_pkg::SBBA_CMD_WRITE;
            3'h6:    c = sbba_pkg::SBBA_CMD_STOP;
            3'h2:    c = sbba_pkg::SBBA_CMD_PRE;
            3'h7:    c = sbba_pkg::SBBA_CMD_NOP;
            default: c = sbba_pkg::SBBA_CMD_OTHER;
         endcase
      end
      return c;
   endfunction

   // Mask of the column bits that cycle within a burst.
   function automatic logic [CW-1:0] wrap_of(input logic [2:0] code);
      logic [CW-1:0] w;
      w = `SBBA_WRAP_1;
      case (code)
         `SBBA_BL_CODE_2:    w = `SBBA_WRAP_2;
         `SBBA_BL_CODE_4:    w = `SBBA_WRAP_4;
         `SBBA_BL_CODE_8:    w = `SBBA_WRAP_8;
         `SBBA_BL_CODE_FULL: w = `SBBA_WRAP_FULL;
         default:            w = `SBBA_WRAP_1;
      endcase
      return w;
   endfunction

   function automatic logic [CW-1:0] beat_col(
      input logic [CW-1:0] start,
      input logic [CW-1:0] k,
      input logic [CW-1:0] wrap,
      input logic          il
   );
      logic [CW-1:0] c;
      if (il) begin
         c = start ^ (k & wrap);
      end else begin
         c = (start & ~wrap) | (CW'(start + k) & wrap);
      end
      return c;
   endfunction

   sbba_pkg::sbba_cmd_t cmd;
   sbba_pkg::sbba_op_t  op_r;
   sbba_pkg::sbba_op_t  op_nxt;
   sbba_pkg::sbba_op_t  cur_op;

   logic [`SBBA_BANKS-1:0]  bank_open_r;
   logic [`SBBA_ADDR_W-1:0] row_r [0:`SBBA_BANKS-1];
   logic [`SBBA_BANK_W-1:0] bank_r;
   logic [CW-1:0]           start_r;
   logic [CW-1:0]           beat_r;
   logic [2:0]              code_r;
   logic                    il_r;
   logic                    ap_r;
   logic                    busy_r;

   logic [`SBBA_BANK_W-1:0] cur_bank;
   logic [CW-1:0]           cur_start;
   logic [CW-1:0]           cur_k;
   logic [2:0]              cur_code;
   logic                    cur_il;
   logic                    cur_ap;
   logic                    cur_full;
   logic [CW-1:0]           cur_wrap;
   logic [CW-1:0]           cur_col;
   logic                    cur_last;
   logic                    new_rd;
   logic                    new_wr;

   logic [1:0]              wap_cnt_r;
   logic [`SBBA_BANK_W-1:0] wap_bank_r;
   logic                    rd_ap_close;

   logic [TW-1:0]           time_r;
   logic [TW-1:0]           cl_m1;
   logic                    fetch_d_r;
   logic [`SBBA_MASK_W-1:0] dqm_d1_r;
   logic [`SBBA_MASK_W-1:0] dqm_d2_r;
   logic                    fifo_in_ready;
   logic                    fifo_out_valid;
   logic                    pop;
   logic [`SBBA_FIFO_W-1:0] fifo_out_data;
   logic [`SBBA_FIFO_W-1:0] fifo_in_data;

   sbba_mem_if mem_bus ();

   assign cmd = decode_cmd(cs_n_i, ras_n_i, cas_n_i, we_n_i);

   // Accesses to a closed bank are dropped rather than touching a stale row.
   assign new_rd = (cmd == sbba_pkg::SBBA_CMD_READ) &&
                   bank_open_r[bank_select_i];
   assign new_wr = (cmd == sbba_pkg::SBBA_CMD_WRITE) &&
                   bank_open_r[bank_select_i];

   // A fresh read or write to an open bank always wins over the burst in flight. A write over a
   // read stops further fetches, but words already fetched still reach the
   // pins, so the controller has to mask them.
   always_comb begin
      cur_op    = op_r;
      cur_bank  = bank_r;
      cur_start = start_r;
      cur_k     = beat_r;
      cur_code  = code_r;
      cur_il    = il_r;
      cur_ap    = ap_r;
      if (new_rd || new_wr) begin
         cur_op    = new_rd ? sbba_pkg::SBBA_OP_READ
                            : sbba_pkg::SBBA_OP_WRITE;
         cur_bank  = bank_select_i;
         cur_start = addr_i[CW-1:0];
         cur_k     = '0;
         cur_code  = mode_burst_len_i;
         cur_il    = mode_interleave_i;
         cur_ap    = addr_i[`SBBA_AP_BIT];
      end else if (cmd == sbba_pkg::SBBA_CMD_STOP &&
                   code_r == `SBBA_BL_CODE_FULL) begin
         // Stop outside a page burst is illegal and is ignored.
         cur_op = sbba_pkg::SBBA_OP_IDLE;
      end
   end

   assign cur_full = (cur_code == `SBBA_BL_CODE_FULL);
   assign cur_wrap = wrap_of(cur_code);
   assign cur_col  = beat_col(cur_start, cur_k, cur_wrap,
                              cur_il && !cur_full);
   // A page burst wraps round the row until it is stopped.
   assign cur_last = !cur_full && (cur_k == cur_wrap);

   always_comb begin
      op_nxt = cur_op;
      if (cur_op != sbba_pkg::SBBA_OP_IDLE && cur_last) begin
         op_nxt = sbba_pkg::SBBA_OP_IDLE;
      end
   end

   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         op_r    <= sbba_pkg::SBBA_OP_IDLE;
         busy_r  <= 1'b0;
         bank_r  <= '0;
         start_r <= '0;
         beat_r  <= '0;
         code_r  <= `SBBA_BL_CODE_1;
         il_r    <= 1'b0;
         ap_r    <= 1'b0;
      end else begin
         op_r    <= op_nxt;
         busy_r  <= (op_nxt != sbba_pkg::SBBA_OP_IDLE);
         bank_r  <= cur_bank;
         start_r <= cur_start;
         beat_r  <= CW'(cur_k + 1'b1);
         code_r  <= cur_code;
         il_r    <= cur_il;
         ap_r    <= cur_ap;
      end
   end

   // Read auto-precharge closes the bank once the beats left after this one
   // fall to the latency minus one; page bursts never auto-precharge.
   assign rd_ap_close = (cur_op == sbba_pkg::SBBA_OP_READ) && cur_ap &&
                        !cur_full &&
                        ({1'b0, cur_wrap} <=
                         (CW + 1)'(cur_k + cl_m1));

   // A pending write auto-precharge is not cancelled by a later command;
   // interrupting such a burst is illegal, so no logic is spent on it.
   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         wap_cnt_r  <= '0;
         wap_bank_r <= '0;
      end else if (cur_op == sbba_pkg::SBBA_OP_WRITE && cur_ap &&
                   !cur_full && cur_last) begin
         wap_cnt_r  <= `SBBA_WR_AP_DELAY;
         wap_bank_r <= cur_bank;
      end else if (wap_cnt_r != 2'h0) begin
         wap_cnt_r  <= wap_cnt_r - 1'b1;
      end
   end

   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         bank_open_r <= '0;
      end else begin
         if (rd_ap_close) begin
            bank_open_r[cur_bank] <= 1'b0;
         end
         if (wap_cnt_r == 2'h1) begin
            bank_open_r[wap_bank_r] <= 1'b0;
         end
         if (cmd == sbba_pkg::SBBA_CMD_PRE) begin
            if (addr_i[`SBBA_AP_BIT]) begin
               bank_open_r <= '0;
            end else begin
               bank_open_r[bank_select_i] <= 1'b0;
            end
         end
         if (cmd == sbba_pkg::SBBA_CMD_ACT) begin
            bank_open_r[bank_select_i] <= 1'b1;
         end
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (cmd == sbba_pkg::SBBA_CMD_ACT) begin
         row_r[bank_select_i] <= addr_i;
      end
   end

   // Only a few row bits reach the store; it models a slice of the array.
   assign mem_bus.addr  = {cur_bank,
                           row_r[cur_bank][`SBBA_STORE_ROW_W-1:0],
                           cur_col};
   assign mem_bus.wr_en = (cur_op == sbba_pkg::SBBA_OP_WRITE);
   assign mem_bus.be    = ~dqm_i;
   assign mem_bus.wdata = dq_i;
   // A full read queue skips the fetch instead of shifting later beats.
   assign mem_bus.rd_en = (cur_op == sbba_pkg::SBBA_OP_READ) &&
                          fifo_in_ready;

   sbba_store u_store (
      .core_clk_i (core_clk_i),
      .mp         (mem_bus)
   );

   assign cl_m1 = TW'(mode_cas_latency_i) - 1'b1;

   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         time_r    <= '0;
         fetch_d_r <= 1'b0;
         dqm_d1_r  <= '1;
         dqm_d2_r  <= '1;
      end else begin
         time_r    <= time_r + 1'b1;
         fetch_d_r <= mem_bus.rd_en;
         dqm_d1_r  <= dqm_i;
         dqm_d2_r  <= dqm_d1_r;
      end
   end

   // Each fetched word carries the cycle it is due on the pins, so data of
   // an interrupted read keeps flowing until the new latency runs out.
   assign fifo_in_data = {TW'(time_r + cl_m1), mem_bus.rdata};

   sbba_fifo #(
      .WIDTH (`SBBA_FIFO_W),
      .DEPTH (`SBBA_FIFO_DEPTH)
   ) u_rd_fifo (
      .core_clk_i  (core_clk_i),
      .nrst_i      (nrst_i),
      .in_valid_i  (fetch_d_r),
      .in_ready_o  (fifo_in_ready),
      .in_data_i   (fifo_in_data),
      .out_valid_o (fifo_out_valid),
      .out_ready_i (pop),
      .out_data_o  (fifo_out_data)
   );

   assign pop = fifo_out_valid &&
                (fifo_out_data[`SBBA_FIFO_W-1 -: TW] == time_r);

   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         dq_o      <= '0;
         dq_oe_n_o <= '1;
      end else if (pop) begin
         dq_o      <= fifo_out_data[`SBBA_DATA_W-1:0];
         dq_oe_n_o <= dqm_d2_r;
      end else begin
         // Once no word is due the pins float; after a stop that is
         // exactly one latency later.
         dq_oe_n_o <= '1;
      end
   end

   assign bank_open_o    = bank_open_r;
   assign burst_active_o = busy_r;
endmodule

// ==== verification/sbba_ctl_model.sv ====
module sbba_ctl_model #(
   parameter int ROW_TO_COLUMN_DELAY = 2,
   parameter int BANK_TO_BANK_DELAY = 2,
   parameter int T_RP  = 2
) (
   input  wire logic   core_clk_i,
   output logic        cs_n_o,
   output logic [2:0]  cmd_o,
   output logic [1:0]  bank_o,
   output logic [11:0] addr_o,
   output logic [3:0]  dqm_o,
   output logic [31:0] dq_o
);
   timeunit 1ns;
   timeprecision 1ps;

   int         cyc = 0;
   int         act_at [4] = '{default: 0};
   logic [3:0] open_r = 4'h0;

   initial begin
      cs_n_o = 1'b1;
      cmd_o = 3'h7;
      bank_o = 2'h0;
      addr_o = 12'h0;
      dqm_o = 4'h0;
      dq_o = 32'h0;
   end

   always @(posedge core_clk_i) cyc <= cyc + 1;

   task automatic issue(input logic [2:0] c, input logic [1:0] b,
                        input logic [11:0] a, input logic [3:0] m,
                        input logic [31:0] d);
      @(negedge core_clk_i);
      cs_n_o = 1'b0;
      cmd_o = c;
      bank_o = b;
      addr_o = a;
      dqm_o = m;
      dq_o = d;
   endtask

   // The bus is released here; a flipping pattern stands in for a floating
   // line so that a stale word never passes for fresh data.
   task automatic idle(input int n);
      repeat (n) begin
         @(negedge core_clk_i);
         cmd_o = 3'h7;
         addr_o = ~addr_o;
         dq_o = ~dq_o;
      end
   endtask

   task automatic activate(input logic [1:0] b, input logic [11:0] row);
      if (open_r[b]) begin
         issue(3'h2, b, 12'h0, dqm_o, dq_o);
         idle(T_RP);
      end
      idle(BANK_TO_BANK_DELAY);
      issue(3'h3, b, row, dqm_o, dq_o);
      act_at[b] = cyc;
      open_r[b] = 1'b1;
   endtask

   task automatic access(input bit rd, input logic [1:0] b,
                         input logic [11:0] a, input logic [3:0] m,
                         input logic [31:0] d);
      while (cyc < act_at[b] + ROW_TO_COLUMN_DELAY) idle(1);
      issue(rd ? 3'h5 : 3'h4, b, a, m, d);
   endtask
endmodule

// ==== verification/sbba_top_properties.sv ====
module sbba_top_properties (
   input wire logic        core_clk_i,
   input wire logic        nrst_i,
   input wire logic        cs_n_i,
   input wire logic        ras_n_i,
   input wire logic        cas_n_i,
   input wire logic        we_n_i,
   input wire logic [1:0]  bank_select_i,
   input wire logic [11:0] addr_i,
   input wire logic [3:0]  dqm_i,
   input wire logic [31:0] dq_i,
   input wire logic [31:0] dq_o,
   input wire logic [3:0]  dq_oe_n_o,
   input wire logic [2:0]  mode_burst_len_i,
   input wire logic        mode_interleave_i,
   input wire logic [1:0]  mode_cas_latency_i,
   input wire logic [3:0]  bank_open_o,
   input wire logic        burst_active_o
);
   timeunit 1ns;
   timeprecision 1ps;

   wire logic [2:0] cmd_w = {ras_n_i, cas_n_i, we_n_i};
   wire logic       nop_w = cs_n_i | (cmd_w == 3'h7);
   wire logic       opn_w = bank_open_o[bank_select_i];
   wire logic       rd_w = !cs_n_i && cmd_w == 3'h5;
   wire logic       wr_w = !cs_n_i && cmd_w == 3'h4 && opn_w;
   wire logic       stp_w = !cs_n_i && cmd_w == 3'h6;

   default clocking @(posedge core_clk_i); endclocking
   default disable iff (!nrst_i);

   a_act_opens_bank :
   assert property (!cs_n_i && cmd_w == 3'h3 |=>
      bank_open_o[$past(bank_select_i)]) else $error("bank not opened");
   a_read_first_beat :
   assert property (rd_w && opn_w && mode_cas_latency_i == 2'h2 &&
      dqm_i == 4'h0 ##1 nop_w |-> ##2 dq_oe_n_o == 4'h0)
      else $error("first read beat not driven");
   a_idle_floats :
   assert property ((!rd_w && !burst_active_o) [*5] |-> dq_oe_n_o == 4'hf)
      else $error("outputs driven while idle");
   a_wr_ap_close :
   assert property (wr_w && addr_i[10] && mode_burst_len_i == 3'h0 ##1
      nop_w [*2] |=> !bank_open_o[$past(bank_select_i, 3)])
      else $error("write auto-precharge late");
   a_burst_four :
   assert property (rd_w && opn_w && mode_burst_len_i == 3'h2 ##1 nop_w [*3]
      |-> burst_active_o ##1 !burst_active_o) else $error("burst length");
   a_page_stop :
   assert property (burst_active_o && stp_w && mode_burst_len_i == 3'h7
      |=> !burst_active_o) else $error("burst stop ignored");
   a_mask_floats :
   assert property (dqm_i == 4'hf |-> ##3 dq_oe_n_o == 4'hf)
      else $error("masked read still driven");
   a_closed_refused :
   assert property (rd_w && !opn_w && !burst_active_o |=> !burst_active_o)
      else $error("closed bank accepted");

   c_read : cover property (rd_w && opn_w ##3 dq_oe_n_o == 4'h0);
   c_wr_ap : cover property (wr_w && addr_i[10]);
   c_stop : cover property (burst_active_o && stp_w);
endmodule

bind sbba_top sbba_top_properties u_props (
   .core_clk_i(core_clk_i), .nrst_i(nrst_i), .cs_n_i(cs_n_i),
   .ras_n_i(ras_n_i), .cas_n_i(cas_n_i), .we_n_i(we_n_i),
   .bank_select_i(bank_select_i), .addr_i(addr_i), .dqm_i(dqm_i),
   .dq_i(dq_i), .dq_o(dq_o), .dq_oe_n_o(dq_oe_n_o),
   .mode_burst_len_i(mode_burst_len_i),
   .mode_interleave_i(mode_interleave_i),
   .mode_cas_latency_i(mode_cas_latency_i),
   .bank_open_o(bank_open_o), .burst_active_o(burst_active_o)
);

// ==== verification/tb_sbba_top.sv ====
module tb_sbba_top;
   timeunit 1ns;
   timeprecision 1ps;

   logic        clk = 1'b0;
   logic        nrst = 1'b0;
   logic        cs_n;
   logic [2:0]  cmd;
   logic [1:0]  bank;
   logic [11:0] addr;
   logic [3:0]  dqm;
   logic [31:0] dq;
   logic [31:0] dq_o;
   logic [3:0]  dq_oe_n_o;
   logic [3:0]  bank_open_o;
   logic        burst_active_o;
   logic [2:0]  mode_bl = 3'h7;
   logic        mode_il = 1'b0;
   logic [1:0]  mode_cl = 2'h2;
   int          seed = 40;
   int          num_errors = 0;
   int          n_compared = 0;
   int          t = 0;
   int          wl = 0;
   int          wk, wbl;
   logic [1:0]  wb;
   logic [8:0]  ws;
   bit          wil;
   logic [3:0]  r_open = 4'h0;
   logic [31:0] mem [2048];
   logic [31:0] e_d [int];
   logic [3:0]  e_m [64];

   always #12.5 clk = ~clk;

   sbba_ctl_model ctl (.core_clk_i(clk), .cs_n_o(cs_n), .cmd_o(cmd),
      .bank_o(bank), .addr_o(addr), .dqm_o(dqm), .dq_o(dq));

   sbba_top dut (.core_clk_i(clk), .nrst_i(nrst), .cs_n_i(cs_n),
      .ras_n_i(cmd[2]), .cas_n_i(cmd[1]), .we_n_i(cmd[0]),
      .bank_select_i(bank), .addr_i(addr), .dqm_i(dqm), .dq_i(dq),
      .dq_o(dq_o), .dq_oe_n_o(dq_oe_n_o), .mode_burst_len_i(mode_bl),
      .mode_interleave_i(mode_il), .mode_cas_latency_i(mode_cl),
      .bank_open_o(bank_open_o), .burst_active_o(burst_active_o));

   function automatic int blen(input logic [2:0] code);
      case (code)
         3'h1: return 2;
         3'h2: return 4;
         3'h3: return 8;
         3'h7: return 512;
         default: return 1;
      endcase
   endfunction

   function automatic logic [8:0] colk(input logic [8:0] s, input int k,
                                       input logic [8:0] w, input bit il);
      // A page burst always runs in sequential order.
      return (il && w != 9'h1ff) ? s ^ (9'(k) & w)
                                 : (s & ~w) | ((s + 9'(k)) & w);
   endfunction

   always @(posedge clk) begin : ref_model
      int bl, cl;
      logic [8:0] c;
      if (nrst) begin
         t = t + 1;
         e_m[(t + 2) % 64] = dqm;
         bl = blen(mode_bl);
         cl = int'(mode_cl);
         if (!cs_n && cmd == 3'h3) r_open[bank] = 1'b1;
         if (!cs_n && cmd == 3'h2) r_open[bank] = 1'b0;
         if (!cs_n && (cmd == 3'h6 || (cmd[2:1] == 2'h2 && r_open[bank])))
         begin
            wl = 0;
            for (int i = t + cl; i < t + cl + 512; i++)
               if (e_d.exists(i)) e_d.delete(i);
            for (int k = 0; k < bl && cmd == 3'h5; k++)
               e_d[t + k + cl] = mem[{bank, colk(addr[8:0], k, 9'(bl - 1),
                                                 mode_il)}];
            if (cmd == 3'h4) begin
               {wl, wk, wbl, wb, ws, wil} = {bl, 0, bl, bank, addr[8:0],
                                              mode_il};
            end
            if (cmd != 3'h6 && addr[10]) r_open[bank] = 1'b0;
         end
         if (wl > 0) begin
            c = colk(ws, wk, 9'(wbl - 1), wil);
            for (int i = 0; i < 4; i++)
               if (!dqm[i]) mem[{wb, c}][8*i +: 8] = dq[8*i +: 8];
            wk++;
            wl--;
         end
      end
   end

   always @(negedge clk) begin : scoreboard
      logic [3:0]  eo;
      logic [31:0] bm;
      if (nrst && t > 0) begin
         eo = e_d.exists(t) ? e_m[t % 64] : 4'hf;
         chk4(dq_oe_n_o, eo);
         for (int i = 0; i < 4; i++) bm[8*i +: 8] = {8{~eo[i]}};
         if (e_d.exists(t)) chk32(dq_o & bm, e_d[t] & bm);
      end
   end

   task automatic chk4(input logic [3:0] g, input logic [3:0] e);
      n_compared++;
      if (g !== e) begin
         num_errors++;
         $display("[ERR] %0t got %h exp %h", $time, g, e);
      end
   endtask

   task automatic chk32(input logic [31:0] g, input logic [31:0] e);
      n_compared++;
      if (g !== e) begin
         num_errors++;
         $display("[ERR] %0t got %h exp %h", $time, g, e);
      end
   endtask

   // Page bursts never end on their own, so each one is closed by a stop.
   task automatic xfer(input bit rd, input logic [1:0] b,
                       input logic [8:0] c, input bit ap, input int n,
                       input bit rm);
      ctl.access(rd, b, {1'b0, ap, 1'b0, c}, 4'h0, 32'($random(seed)));
      repeat (n - 1)
         ctl.issue(3'h7, b, 12'($random(seed)),
                   rm ? 4'($random(seed)) : 4'h0, 32'($random(seed)));
      if (mode_bl == 3'h7)
         ctl.issue(3'h6, b, 12'($random(seed)), 4'($random(seed)),
                   32'($random(seed)));
      ctl.idle(1);
   endtask

   task automatic end_of_test();
      $display("comparisons %0d, errors %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   initial begin : watchdog
      #500us;
      num_errors++;
      end_of_test();
   end

   initial begin : main
      logic [1:0] b;
      logic [8:0] c;
      repeat (4) @(posedge clk);
      @(negedge clk) nrst = 1'b1;
      chk4(dq_oe_n_o, 4'hf);
      chk4(bank_open_o, 4'h0);
      for (int i = 0; i < 4; i++) ctl.activate(2'(i), 12'(i));
      ctl.idle(2);
      chk4(bank_open_o, 4'hf);
      for (int i = 0; i < 4; i++) xfer(0, 2'(i), 9'h0, 0, 512, 0);
      for (int i = 0; i < 16; i++) begin
         mode_bl = 3'(i % 4);
         mode_il = i[2];
         mode_cl = i[3] ? 2'h3 : 2'h2;
         b = 2'($random(seed));
         c = 9'($random(seed));
         xfer(0, b, c, 0, blen(mode_bl), 1);
         xfer(1, b, c, 0, blen(mode_bl), 1);
         ctl.idle(4);
      end
      mode_bl = 3'h2;
      xfer(0, 2'h1, 9'h20, 0, 2, 0);
      xfer(0, 2'h1, 9'h42, 0, 4, 1);
      xfer(1, 2'h1, 9'h20, 0, 4, 0);
      xfer(1, 2'h1, 9'h40, 0, 4, 0);
      mode_bl = 3'h3;
      xfer(0, 2'h0, 9'h13, 0, 3, 1);
      xfer(1, 2'h0, 9'h13, 0, 8, 0);
      ctl.idle(4);
      for (int i = 0; i < 6; i++)
         ctl.access(1, 2'(i), 12'($random(seed)) & 12'h1ff,
                    4'($random(seed)), 32'($random(seed)));
      ctl.idle(12);
      mode_bl = 3'h7;
      xfer(1, 2'h2, 9'h1f0, 0, 24, 1);
      ctl.idle(8);
      mode_bl = 3'h0;
      xfer(0, 2'h2, 9'h5, 1, 1, 0);
      ctl.idle(3);
      chk4(bank_open_o & 4'h4, 4'h0);
      xfer(1, 2'h2, 9'h5, 0, 1, 0);
      ctl.idle(4);
      mode_bl = 3'h2;
      mode_cl = 2'h3;
      xfer(1, 2'h3, 9'h7, 1, 4, 0);
      ctl.idle(6);
      chk4(bank_open_o & 4'h8, 4'h0);
      ctl.activate(2'h2, 12'h2);
      xfer(1, 2'h2, 9'h5, 0, 4, 0);
      ctl.idle(8);
      // A write cuts a read short; the mask floats the two fetched words.
      ctl.access(1, 2'h2, 12'h10, 4'h0, 32'h0);
      ctl.issue(3'h7, 2'h2, 12'h0, 4'hf, 32'h0);
      ctl.access(0, 2'h2, 12'h30, 4'hf, 32'($random(seed)));
      repeat (3)
         ctl.issue(3'h7, 2'h2, 12'h0, 4'h0, 32'($random(seed)));
      ctl.idle(6);
      xfer(1, 2'h2, 9'h30, 0, 4, 0);
      ctl.idle(6);
      end_of_test();
   end
endmodule
